// >>> mrida_params.svh
// constants for the instruction decoder and address former
// assumes inclusion by bare name from every design file that needs it
`ifndef MRIDA_PARAMS_SVH
`define MRIDA_PARAMS_SVH

////////////////////////////////////////////////////////////////////////
// word and memory geometry
`define MRIDA_WORD_W       12
`define MRIDA_FIELD_WORDS  4096
`define MRIDA_FIELD_LAST   3'h7
`define MRIDA_ADDR_LAST    12'hFFF
`define MRIDA_PAGES        32
`define MRIDA_PAGE_WORDS   128
`define MRIDA_PAGE_W       5
`define MRIDA_OFFS_W       7
`define MRIDA_ZERO_PAGE    5'h00

////////////////////////////////////////////////////////////////////////
// instruction field positions, bit 0 is the most significant
`define MRIDA_OP_HI        0
`define MRIDA_OP_LO        2
`define MRIDA_IND_BIT      3
`define MRIDA_PAGE_BIT     4
`define MRIDA_OFFS_HI      5
`define MRIDA_OFFS_LO      11
`define MRIDA_OP_LAST_MRI  3'h4
`define MRIDA_OP_JUMP      3'h5
`define MRIDA_OP_IOT       3'h6
`define MRIDA_OP_OPR       3'h7

////////////////////////////////////////////////////////////////////////
// register port
`define MRIDA_RA_W         8
`define MRIDA_RD_W         16
`define MRIDA_REG_CTRL     8'h00
`define MRIDA_REG_PC       8'h01
`define MRIDA_REG_STATE    8'h02
`define MRIDA_REG_INSTR    8'h03
`define MRIDA_REG_EADDR    8'h04
`define MRIDA_REG_ICOUNT   8'h05
`define MRIDA_CTRL_RUN     0
`define MRIDA_CTRL_STEP    1
`define MRIDA_CTRL_RESET   2'h0
`define MRIDA_PC_RESET     12'h000
`define MRIDA_WORD_RESET   12'h000
`define MRIDA_DISPLAY_RESET 12'h800

`endif

// >>> mrida_pkg.sv
// types shared by the decoder files
// assumes mrida_params.svh is available on the include path
`include "mrida_params.svh"

package mrida_pkg;
	// bit 0 is the high-order bit of every word
	typedef logic [0:`MRIDA_WORD_W-1] mrida_word_t;

	typedef enum logic [1:0] {
		MC_FETCH,
		MC_POINTER_CYCLE,
		MC_EXEC
	} mrida_major_t;
endpackage

// >>> mrida_op_decode.sv
// one-hot decode of the three-bit operation field
// assumes a combinational caller on the same clock
`timescale 1ns/100ps
`include "mrida_params.svh"

module mrida_op_decode (
	input  wire logic [2:0] opcode,
	output logic      [7:0] op_onehot,
	output logic            is_memory_ref,
	output logic            uses_address,
	output logic            is_augmented
);

	////////////////////////////////////////////////////////////////////////
	// 0 and, 1 add, 2 inc-skip, 3 deposit, 4 call, 5 jump, 6 io, 7 operate
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_op
			assign op_onehot[i] = (opcode == 3'(i)); // RULE16 RULE17 RULE18
		end
	endgenerate

	assign is_memory_ref = (opcode <= `MRIDA_OP_LAST_MRI); // RULE9
	assign uses_address  = (opcode <= `MRIDA_OP_JUMP); // RULE17
	assign is_augmented  = (opcode == `MRIDA_OP_IOT) || (opcode == `MRIDA_OP_OPR); // RULE18

endmodule

// >>> mrida_addr_form.sv
// forms the in-field address from page bit, offset and instruction location
// assumes the caller supplies the address the instruction was fetched from
`timescale 1ns/100ps
`include "mrida_params.svh"

module mrida_addr_form (
	input  wire mrida_pkg::mrida_word_t instr_word,
	input  wire mrida_pkg::mrida_word_t instr_loc,
	output mrida_pkg::mrida_word_t      formed_addr
);

	logic [0:`MRIDA_PAGE_W-1] page_sel;

	// page zero instructions see page zero either way, no special case needed
	assign page_sel = instr_word[`MRIDA_PAGE_BIT]
		? instr_loc[0:`MRIDA_PAGE_W-1]
		: `MRIDA_ZERO_PAGE; // RULE13 RULE14

	assign formed_addr = {page_sel, instr_word[`MRIDA_OFFS_HI:`MRIDA_OFFS_LO]}; // RULE4 RULE5

endmodule

// >>> mrida_decode_and_address_form.sv
// instruction classification and effective address formation
// assumes memory on the same clock answers each read with a one-cycle ack
//
// Behaviour
// RULE1: display bits 0-2 show fetch, pointer, execute
// RULE2: display bits 3-5 show held opcode
// RULE3: twelve-bit addresses span one 4096-word field
// RULE4: field is 32 pages of 128 words
// RULE5: top five bits page, low seven offset
// RULE6: counter wraps pages with no detection
// RULE7: bit 0 is the most significant
// RULE8: every fetched word executes as instruction
// RULE9: memory ops 0-4, address in low nine
// RULE10: augmented words pass all twelve bits
// RULE11: jump only loads the program counter
// RULE12: indirect bit makes formed address a pointer
// RULE13: page bit picks current page or zero
// RULE14: page-zero code always reaches page zero
// RULE15: full twelve-bit pointer reaches whole field
// RULE16: opcodes 0-4 decode to five memory ops
// RULE17: opcode 5 decodes as jump with addressing
// RULE18: opcodes 6 and 7 are augmented
// RULE19: indirect goes through pointer cycle first
// RULE20: reset gives fetch with cleared opcode register
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "mrida_params.svh"

module mrida_decode_and_address_form (
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// register port
	input  wire logic [`MRIDA_RA_W-1:0]   reg_addr,
	input  wire logic [`MRIDA_RD_W-1:0]   reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [`MRIDA_RD_W-1:0]   reg_rdata,
	// memory read port
	output logic                          mem_req,
	output mrida_pkg::mrida_word_t        mem_addr,
	input  wire logic                     mem_ack,
	input  wire mrida_pkg::mrida_word_t   mem_rdata,
	// execute hand-off
	output logic                          exec_valid,
	output logic      [7:0]               exec_op,
	output logic                          exec_memory_ref,
	output logic                          exec_augmented,
	output mrida_pkg::mrida_word_t        exec_addr,
	output mrida_pkg::mrida_word_t        exec_word,
	output mrida_pkg::mrida_word_t        exec_pc,
	// console
	output mrida_pkg::mrida_word_t        state_display,
	output logic                          halted
);

	////////////////////////////////////////////////////////////////////////
	// state

	mrida_pkg::mrida_major_t major;
	mrida_pkg::mrida_major_t next_major;
	mrida_pkg::mrida_word_t  program_counter_reg;
	mrida_pkg::mrida_word_t  opcode_hold_reg;
	mrida_pkg::mrida_word_t  next_opcode_hold;
	mrida_pkg::mrida_word_t  eff_addr;
	mrida_pkg::mrida_word_t  formed_addr;
	mrida_pkg::mrida_word_t  instr_count;
	logic                    wait_ack;
	logic                    run;
	logic                    step;
	logic                    fetch_done;
	logic                    pointer_cycle_done;
	logic                    issue;
	logic                    go_pointer_cycle;
	logic                    pc_writable;
	logic [7:0]              fetch_onehot;
	logic                    fetch_memory_ref;
	logic                    fetch_uses_address;
	logic                    fetch_augmented;
	logic [7:0]              held_onehot;
	logic                    held_memory_ref;
	logic                    held_augmented;

	////////////////////////////////////////////////////////////////////////
	// decode of the word coming back from memory

	mrida_op_decode u_fetch_decode (
		.opcode        (mem_rdata[`MRIDA_OP_HI:`MRIDA_OP_LO]),
		.op_onehot     (fetch_onehot),
		.is_memory_ref (fetch_memory_ref),
		.uses_address  (fetch_uses_address),
		.is_augmented  (fetch_augmented)
	);

	// address formed from the word just fetched and where it came from
	mrida_addr_form u_addr_form (
		.instr_word  (mem_rdata),
		.instr_loc   (program_counter_reg),
		.formed_addr (formed_addr)
	);

	////////////////////////////////////////////////////////////////////////
	// cycle sequencing

	assign fetch_done = (major == mrida_pkg::MC_FETCH) && wait_ack && mem_ack;
	assign pointer_cycle_done = (major == mrida_pkg::MC_POINTER_CYCLE) && wait_ack && mem_ack;
	// data and instructions are not told apart: any ack'd word is decoded
	assign go_pointer_cycle   = fetch_uses_address && mem_rdata[`MRIDA_IND_BIT]; // RULE8 RULE12
	// a new read goes out only when none is outstanding
	assign issue      = !wait_ack && !mem_req
		&& (((major == mrida_pkg::MC_FETCH) && run) || (major == mrida_pkg::MC_POINTER_CYCLE));
	assign pc_writable = !run && (major == mrida_pkg::MC_FETCH) && !wait_ack && !mem_req;

	always_comb begin
		next_major = major;
		unique case (major)
			mrida_pkg::MC_FETCH: begin
				if (fetch_done) begin
					next_major = go_pointer_cycle ? mrida_pkg::MC_POINTER_CYCLE : mrida_pkg::MC_EXEC; // RULE19
				end
			end
			mrida_pkg::MC_POINTER_CYCLE: begin
				if (pointer_cycle_done) begin
					next_major = mrida_pkg::MC_EXEC; // RULE19
				end
			end
			mrida_pkg::MC_EXEC: begin
				next_major = mrida_pkg::MC_FETCH;
			end
			default: begin
				next_major = mrida_pkg::MC_FETCH;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			major <= mrida_pkg::MC_FETCH; // RULE20
		end else begin
			major <= next_major;
		end
	end

	always_comb begin
		next_opcode_hold = opcode_hold_reg;
		if (fetch_done) begin
			next_opcode_hold = mem_rdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			opcode_hold_reg <= `MRIDA_WORD_RESET; // RULE20
		end else if (fetch_done) begin
			opcode_hold_reg <= next_opcode_hold;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory reads

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mem_req  <= 1'b0;
			mem_addr <= `MRIDA_WORD_RESET;
			wait_ack <= 1'b0;
		end else begin
			mem_req <= issue;
			if (issue) begin
				mem_addr <= (major == mrida_pkg::MC_POINTER_CYCLE) ? eff_addr : program_counter_reg;
				wait_ack <= 1'b1;
			end else if (wait_ack && mem_ack) begin
				wait_ack <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter and effective address

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			program_counter_reg <= `MRIDA_PC_RESET;
		end else if (fetch_done) begin
			// plain 12-bit wrap, page boundaries are invisible
			program_counter_reg <= mrida_pkg::mrida_word_t'(program_counter_reg + 12'h001); // RULE3 RULE6
		end else if ((major == mrida_pkg::MC_EXEC) && held_onehot[`MRIDA_OP_JUMP]) begin
			program_counter_reg <= eff_addr; // RULE11
		end else if (reg_wr && (reg_addr == `MRIDA_REG_PC) && pc_writable) begin
			program_counter_reg <= reg_wdata[`MRIDA_WORD_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			eff_addr <= `MRIDA_WORD_RESET;
		end else if (fetch_done) begin
			// augmented words carry no address
			eff_addr <= fetch_uses_address ? formed_addr : `MRIDA_WORD_RESET; // RULE10 RULE13
		end else if (pointer_cycle_done) begin
			eff_addr <= mem_rdata; // RULE12 RULE15
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			held_onehot     <= 8'h00;
			held_memory_ref <= 1'b0;
			held_augmented  <= 1'b0;
		end else if (fetch_done) begin
			held_onehot     <= fetch_onehot; // RULE16 RULE17 RULE18
			held_memory_ref <= fetch_memory_ref; // RULE9
			held_augmented  <= fetch_augmented; // RULE10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// execute hand-off, valid for exactly the execute cycle

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			exec_valid      <= 1'b0;
			exec_op         <= 8'h00;
			exec_memory_ref <= 1'b0;
			exec_augmented  <= 1'b0;
			exec_addr       <= `MRIDA_WORD_RESET;
			exec_word       <= `MRIDA_WORD_RESET;
			exec_pc         <= `MRIDA_WORD_RESET;
		end else begin
			exec_valid <= (next_major == mrida_pkg::MC_EXEC);
			if (fetch_done && !go_pointer_cycle) begin
				exec_op         <= fetch_onehot;
				exec_memory_ref <= fetch_memory_ref;
				exec_augmented  <= fetch_augmented;
				exec_addr       <= fetch_uses_address ? formed_addr : `MRIDA_WORD_RESET;
				exec_word       <= mem_rdata; // RULE10
				exec_pc         <= mrida_pkg::mrida_word_t'(program_counter_reg + 12'h001);
			end else if (pointer_cycle_done) begin
				exec_op         <= held_onehot;
				exec_memory_ref <= held_memory_ref;
				exec_augmented  <= held_augmented;
				exec_addr       <= mem_rdata; // RULE15
				exec_word       <= opcode_hold_reg;
				exec_pc         <= program_counter_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// console state display, follows the cycle it shows without lag

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_display <= `MRIDA_DISPLAY_RESET;
		end else begin
			state_display <= `MRIDA_WORD_RESET;
			state_display[0] <= (next_major == mrida_pkg::MC_FETCH); // RULE1 RULE7
			state_display[1] <= (next_major == mrida_pkg::MC_POINTER_CYCLE); // RULE1
			state_display[2] <= (next_major == mrida_pkg::MC_EXEC); // RULE1
			state_display[3:5] <= next_opcode_hold[`MRIDA_OP_HI:`MRIDA_OP_LO]; // RULE2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// run control; a software set wins over the end-of-step clear

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			run  <= 1'b0;
			step <= 1'b0;
		end else if (reg_wr && (reg_addr == `MRIDA_REG_CTRL)) begin
			run  <= reg_wdata[`MRIDA_CTRL_RUN];
			step <= reg_wdata[`MRIDA_CTRL_STEP];
		end else if ((major == mrida_pkg::MC_EXEC) && step) begin
			run <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			halted <= 1'b1;
		end else begin
			halted <= !run && (next_major == mrida_pkg::MC_FETCH) && !issue && !wait_ack;
		end
	end

	// counts instructions handed to execute; a write clears it, except in an execute cycle, where the count goes up instead
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			instr_count <= `MRIDA_WORD_RESET;
		end else if (major == mrida_pkg::MC_EXEC) begin
			instr_count <= mrida_pkg::mrida_word_t'(instr_count + 12'h001);
		end else if (reg_wr && (reg_addr == `MRIDA_REG_ICOUNT)) begin
			instr_count <= `MRIDA_WORD_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register reads, data valid only in the cycle after the strobe

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`MRIDA_REG_CTRL:   reg_rdata <= {14'h0000, step, run};
				`MRIDA_REG_PC:     reg_rdata <= {4'h0, program_counter_reg};
				`MRIDA_REG_STATE:  reg_rdata <= {4'h0, state_display};
				`MRIDA_REG_INSTR:  reg_rdata <= {4'h0, opcode_hold_reg};
				`MRIDA_REG_EADDR:  reg_rdata <= {4'h0, eff_addr};
				`MRIDA_REG_ICOUNT: reg_rdata <= {4'h0, instr_count};
				default:           reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

endmodule

// >>> mrida_dec_props.sv
// checker for the decoder's console lamps and execute hand-off
// assumes it is bound onto the top decoder module, one clock domain
`timescale 1ns/100ps

module mrida_dec_props (
	input wire logic                   ref_clk,
	input wire logic                   rst,
	input wire logic                   mem_req,
	input wire logic                   mem_ack,
	input wire mrida_pkg::mrida_word_t mem_rdata,
	input wire logic                   exec_valid,
	input wire logic [7:0]             exec_op,
	input wire logic                   exec_memory_ref,
	input wire logic                   exec_augmented,
	input wire mrida_pkg::mrida_word_t exec_addr,
	input wire mrida_pkg::mrida_word_t exec_word,
	input wire mrida_pkg::mrida_word_t exec_pc,
	input wire mrida_pkg::mrida_word_t state_display
);
	logic [11:0] here;
	logic        ind_word;
	// fetch location: undo the increment made at fetch
	assign here = exec_pc - 12'h001;
	// augmented words never take a pointer cycle
	assign ind_word = mem_rdata[3] && (mem_rdata[0:1] != 2'h3);

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////
	a_one_state: assert property ($onehot(state_display[0:2]))
		else $error("major cycle lamps not one-hot");
	a_exec_gap: assert property (exec_valid |=> !exec_valid [*2])
		else $error("execute cycles too close");
	a_exec_lamp: assert property (exec_valid |-> state_display[0:5] == {3'b001, exec_word[0:2]})
		else $error("execute lamp or opcode lamps wrong");
	a_op_onehot: assert property (exec_valid |-> exec_op == (8'h01 << exec_word[0:2]))
		else $error("opcode decode wrong");
	a_class_bits: assert property (exec_valid |-> exec_memory_ref == (exec_word[0:2] <= 3'h4)
		&& exec_augmented == (exec_word[0:2] >= 3'h6))
		else $error("instruction class wrong");
	a_aug_noaddr: assert property (exec_valid && exec_augmented |-> exec_addr == 12'h000)
		else $error("augmented word carries an address");
	a_direct_addr: assert property (exec_valid && !exec_augmented && !exec_word[3]
		|-> exec_addr == {(exec_word[4] ? here[11:7] : 5'h00), exec_word[5:11]})
		else $error("direct address formed wrong");
	a_pointer_cycle_entry: assert property (state_display[0] && mem_ack
		|=> state_display[1] == $past(ind_word))
		else $error("pointer cycle choice wrong");
	a_pointer_cycle_read: assert property ($rose(state_display[1]) |-> ##[0:2] mem_req)
		else $error("pointer cycle without read");
	a_pointer_cycle_exit: assert property (state_display[1] && mem_ack
		|=> exec_valid && exec_addr == $past(mem_rdata))
		else $error("pointer word not used as address");
	a_reset_fetch: assert property (disable iff (1'b0) rst |=> state_display == 12'h800 && !exec_valid)
		else $error("reset state wrong");

	c_indirect: cover property (exec_valid && exec_word[3] && exec_memory_ref);
	c_augment: cover property (exec_valid && exec_augmented);
	c_jump: cover property (exec_valid && exec_op == 8'h20);
endmodule

bind mrida_decode_and_address_form mrida_dec_props u_props (
	.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req), .mem_ack(mem_ack),
	.mem_rdata(mem_rdata), .exec_valid(exec_valid), .exec_op(exec_op),
	.exec_memory_ref(exec_memory_ref), .exec_augmented(exec_augmented),
	.exec_addr(exec_addr), .exec_word(exec_word), .exec_pc(exec_pc),
	.state_display(state_display)
);

// >>> mrida_mem_model.sv
// behavioural main memory, one field, one read outstanding
// assumes the bench preloads m[] and sets lat (1..3 cycles)
`timescale 1ns/100ps

module mrida_mem_model (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             mem_req,
	input  wire mrida_pkg::mrida_word_t mem_addr,
	input  wire logic [1:0]       lat,
	output logic                  mem_ack,
	output mrida_pkg::mrida_word_t mem_rdata
);
	logic [11:0] m [0:4095];
	logic [11:0] a;
	logic [11:0] last;
	logic [1:0]  cnt;
	logic        busy;

	initial begin
		mem_ack = 1'b0;
		mem_rdata = 12'h000;
		last = 12'h000;
		busy = 1'b0;
		for (int k = 0; k < 4096; k++)
			m[k] = 12'hE00;
	end

	// data lines show garbage outside the ack cycle
	always @(posedge ref_clk) begin
		if (!rst && !mem_req && busy && cnt <= 2'h1) begin
			mem_ack <= 1'b1;
			mem_rdata <= m[a];
			last <= m[a];
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~last;
		end
		if (rst) begin
			busy <= 1'b0;
		end else if (mem_req) begin
			a <= mem_addr;
			cnt <= lat;
			busy <= 1'b1;
		end else if (busy) begin
			if (cnt <= 2'h1) begin
				busy <= 1'b0;
			end else begin
				cnt <= cnt - 2'h1;
			end
		end
	end
endmodule

// >>> test_mrida_decode_and_address_form.sv
// bench: single-steps a short program through the decoder
// assumes the design files, checker and memory model compile first
`timescale 1ns/100ps
`include "mrida_params.svh"

module test_mrida_decode_and_address_form;
	logic                   ref_clk, rst, reg_wr, reg_rd, halted;
	logic                   mem_req, mem_ack, exec_valid, exec_memory_ref, exec_augmented;
	logic [7:0]             reg_addr, exec_op;
	logic [15:0]            reg_wdata, reg_rdata;
	logic [1:0]             lat;
	mrida_pkg::mrida_word_t mem_addr, mem_rdata, exec_addr, exec_word, exec_pc, state_display;
	int                     bad_count, cmp_count, i, n;
	logic [11:0]            loc [10], wrd [10], ea [10];

	mrida_decode_and_address_form uut (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.exec_valid(exec_valid), .exec_op(exec_op), .exec_memory_ref(exec_memory_ref),
		.exec_augmented(exec_augmented), .exec_addr(exec_addr), .exec_word(exec_word),
		.exec_pc(exec_pc), .state_display(state_display), .halted(halted));

	mrida_mem_model mem (
		.ref_clk(ref_clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
		.lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	always #5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string what);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		cmp(reg_rdata, exp, what);
	endtask

	// bounded wait for execute pulse (ex=1) or halt (ex=0)
	task automatic wait_sig(input bit ex);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (n < 60 && (ex ? exec_valid : halted) !== 1'b1);
		if (n >= 60)
			cmp(16'h0001, 16'h0000, "wait expired");
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#30000;
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		final_report;
	end

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		lat = 2'h1;
		// crosses pages 0/1, page-zero and current-page refs, pointers, wrap at FFF
		loc = '{12'h07F, 12'h080, 12'h081, 12'h082, 12'h083, 12'h084, 12'h085, 12'h086,
			12'h0C0, 12'hFFF};
		wrd = '{12'h0FF, 12'h285, 12'h410, 12'h720, 12'h9FF, 12'hD55, 12'hF01, 12'hAC0,
			12'hB30, 12'h0FF};
		ea = '{12'h07F, 12'h085, 12'h010, 12'hABC, 12'hFFF, 12'h000, 12'h000, 12'h0C0,
			12'hFFF, 12'hFFF};
		#1;
		for (i = 0; i < 10; i++)
			mem.m[loc[i]] = wrd[i];
		mem.m[12'h020] = 12'hABC;
		mem.m[12'h0FF] = 12'hFFF;
		mem.m[12'h030] = 12'hFFF;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;

		rdc(`MRIDA_REG_PC, 16'h0000, "pc after reset");
		rdc(`MRIDA_REG_STATE, 16'h0800, "display after reset");
		rdc(`MRIDA_REG_INSTR, 16'h0000, "held word after reset");
		wr(`MRIDA_REG_STATE, 16'h0123);
		rdc(`MRIDA_REG_STATE, 16'h0800, "display not writable");
		rdc(8'h3F, 16'h0000, "unmapped read");
		wr(`MRIDA_REG_PC, 16'h007F);
		rdc(`MRIDA_REG_PC, 16'h007F, "pc load");
		$display("test reset done");

		for (i = 0; i < 10; i++) begin
			lat <= 2'(i % 3 + 1);
			wr(`MRIDA_REG_CTRL, 16'h0003);
			wait_sig(1'b1);
			cmp({4'h0, exec_addr}, {4'h0, ea[i]}, "operand address");
			cmp({4'h0, exec_pc}, {4'h0, loc[i] + 12'h001}, "pc after fetch");
			cmp({4'h0, exec_word}, {4'h0, wrd[i]}, "instruction word");
			cmp({8'h00, exec_op}, {8'h00, 8'h01 << wrd[i][11:9]}, "opcode");
			cmp({4'h0, state_display}, {4'h0, 3'b001, wrd[i][11:9], 6'h00}, "lamps");
			cmp({14'h0, exec_memory_ref, exec_augmented},
				{14'h0, wrd[i][11:9] <= 3'h4, wrd[i][11:9] >= 3'h6}, "class");
			wait_sig(1'b0);
		end
		$display("test program done");

		rdc(`MRIDA_REG_PC, 16'h0000, "pc wraps");
		rdc(`MRIDA_REG_INSTR, 16'h00FF, "held word");
		rdc(`MRIDA_REG_EADDR, 16'h0FFF, "last address");
		rdc(`MRIDA_REG_ICOUNT, 16'h000A, "executed count");
		wr(`MRIDA_REG_ICOUNT, 16'h0000);
		rdc(`MRIDA_REG_ICOUNT, 16'h0000, "count cleared");
		$display("test registers done");

		// free run, then the step bit stops it after exactly one more instruction
		wr(`MRIDA_REG_PC, 16'h0200);
		wr(`MRIDA_REG_CTRL, 16'h0001);
		wait_sig(1'b1);
		cmp({15'h0, exec_augmented}, 16'h0001, "free run word");
		wr(`MRIDA_REG_CTRL, 16'h0003);
		wait_sig(1'b0);
		rdc(`MRIDA_REG_ICOUNT, 16'h0002, "free run count");
		rdc(`MRIDA_REG_PC, 16'h0202, "free run pc");
		$display("test free run done");
		final_report;
	end
endmodule
